// ### hdl/adcss_pkg.sv
// package of constants for the converter start-up sequencer
// Operation
// - sequence targets bypass mode, twelve-bit samples, link parameters 82820
// - drive the frame reference before issuing the hardware reset pulse
// - reset pin is active high: low, high, low
// - wait at least 1 ms after power-up before asserting reset
// - hold reset high for at least 1 us
// - wait at least 100 ns after reset release before port select
// - load the analog trim set after every power-up
// - load interleaving sets, channel A then channel B
// - wait 50 ms after interleaving sets for error estimation
// - load nonlinearity sets, channel A then channel B
// - finally configure serial data link and down-conversion block
package adcss_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int PWRUP_MS = 1;
	localparam int RST_US = 1;
	localparam int SEL_NS = 100;
	localparam int ILWAIT_MS = 50;
	localparam int PWRUP_CYC = PWRUP_MS * 1000 * CLK_MHZ;
	localparam int RST_CYC = RST_US * CLK_MHZ;
	localparam int SEL_CYC = (SEL_NS * CLK_MHZ + 999) / 1000;
	localparam int ILWAIT_CYC = ILWAIT_MS * 1000 * CLK_MHZ;
	localparam int CNT_W = 32;
	// ----------------------------------------
	// mode the sequence is meant for
	// ----------------------------------------
	localparam int SAMPLE_BITS = 12;
	localparam int LINK_PARAMS = 82820;
	// ----------------------------------------
	// configuration sets, in load order
	// ----------------------------------------
	localparam logic [2:0] SET_TRIM = 3'h0;
	localparam logic [2:0] SET_IL_A = 3'h1;
	localparam logic [2:0] SET_IL_B = 3'h2;
	localparam logic [2:0] SET_NL_A = 3'h3;
	localparam logic [2:0] SET_NL_B = 3'h4;
	localparam logic [2:0] SET_LINK = 3'h5;
	localparam int SET_N = 6;
	// ----------------------------------------
	// serial write framing and table memory
	// ----------------------------------------
	localparam int WR_BITS = 24;
	localparam int SCK_HALF = 5;
	localparam int MEM_AW = 8;
	localparam int MEM_DW = 24;
	localparam logic [23:0] END_WORD = 24'hFFFFFF;

	typedef enum logic [3:0] {
		ST_PWRUP = 4'h0,
		ST_RST = 4'h1,
		ST_SETTLE = 4'h2,
		ST_FETCH = 4'h3,
		ST_LOAD = 4'h4,
		ST_SHIFT = 4'h5,
		ST_GAP = 4'h6,
		ST_ILWAIT = 4'h7,
		ST_DONE = 4'h8
	} adcss_state_t;
endpackage : adcss_pkg

// ### hdl/adcss_mem_if.sv
// interface between sequencer and its write-table memory
`timescale 1ns/10ps
interface adcss_mem_if;
	logic [adcss_pkg::MEM_AW-1:0] addr;
	logic [adcss_pkg::MEM_DW-1:0] rdata;
	logic we;
	logic [adcss_pkg::MEM_AW-1:0] waddr;
	logic [adcss_pkg::MEM_DW-1:0] wdata;
	modport ctrl (output addr, output we, output waddr, output wdata, input rdata);
	modport mem (input addr, input we, input waddr, input wdata, output rdata);
endinterface : adcss_mem_if

// ### hdl/adcss_mem.sv
// write-table memory with registered read data
`timescale 1ns/10ps
module adcss_mem (
	// clock
	input wire logic sys_clk,
	input wire logic ce,
	// access
	adcss_mem_if.mem mi
);
	logic [adcss_pkg::MEM_DW-1:0] store [0:(1<<adcss_pkg::MEM_AW)-1];
	logic [adcss_pkg::MEM_DW-1:0] rd;

	// no reset: contents are loaded by the user before start
	always_ff @(posedge sys_clk) begin
		if (ce) begin
			if (mi.we) begin
				store[mi.waddr] <= mi.wdata;
			end
			rd <= store[mi.addr];
		end
	end
	assign mi.rdata = rd;
endmodule : adcss_mem

// ### hdl/adcss_seq.sv
// host sequencer: reset pin, frame reference and serial writes for start-up
`timescale 1ns/10ps
module adcss_seq (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	// user control
	input wire logic start,
	input wire logic tbl_we,
	input wire logic [7:0] tbl_addr,
	input wire logic [23:0] tbl_data,
	input wire logic [7:0] set_base_0,
	input wire logic [7:0] set_base_1,
	input wire logic [7:0] set_base_2,
	input wire logic [7:0] set_base_3,
	input wire logic [7:0] set_base_4,
	input wire logic [7:0] set_base_5,
	output logic busy,
	output logic done,
	output logic [2:0] cur_set,
	// device pins
	output logic sysref_en,
	output logic dev_reset,
	output logic serial_port_select_n,
	output logic sclk,
	output logic sdata
);
	// ----------------------------------------
	// table memory
	// ----------------------------------------
	adcss_mem_if mi ();
	adcss_mem u_mem (
		.sys_clk(sys_clk),
		.ce(ce),
		.mi(mi)
	);

	adcss_pkg::adcss_state_t state, next_state;
	logic [adcss_pkg::CNT_W-1:0] cnt, next_cnt;
	logic [7:0] ptr, next_ptr;
	logic [2:0] set, next_set;
	logic [23:0] shreg, next_shreg;
	logic [4:0] bitn, next_bitn;
	logic next_sysref, next_rst, next_sel_n, next_sclk, next_sdata, next_busy, next_done;
	logic [7:0] base;

	always_comb begin
		case (set)
			adcss_pkg::SET_TRIM: base = set_base_0;
			adcss_pkg::SET_IL_A: base = set_base_1;
			adcss_pkg::SET_IL_B: base = set_base_2;
			adcss_pkg::SET_NL_A: base = set_base_3;
			adcss_pkg::SET_NL_B: base = set_base_4;
			default: base = set_base_5;
		endcase
	end

	assign mi.addr = ptr;
	assign mi.we = tbl_we;
	assign mi.waddr = tbl_addr;
	assign mi.wdata = tbl_data;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// each set is a run of 24-bit words in the table ending in an all-ones word;
	// the order of sets is fixed by their codes: trim, IL A/B, NL A/B, link
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_ptr = ptr;
		next_set = set;
		next_shreg = shreg;
		next_bitn = bitn;
		next_sysref = sysref_en;
		next_rst = dev_reset;
		next_sel_n = serial_port_select_n;
		next_sclk = sclk;
		next_sdata = sdata;
		next_busy = busy;
		next_done = done;
		case (state)
			adcss_pkg::ST_PWRUP: begin
				next_sel_n = 1'b1;
				next_rst = 1'b0;
				if (start) begin
					next_sysref = 1'b1;
					next_busy = 1'b1;
					next_done = 1'b0;
				end
				if (sysref_en) begin
					next_cnt = cnt + 1'b1;
					if (cnt >= adcss_pkg::CNT_W'(adcss_pkg::PWRUP_CYC - 1)) begin
						next_cnt = '0;
						next_rst = 1'b1;
						next_state = adcss_pkg::ST_RST;
					end
				end
			end
			adcss_pkg::ST_RST: begin
				next_cnt = cnt + 1'b1;
				if (cnt >= adcss_pkg::CNT_W'(adcss_pkg::RST_CYC - 1)) begin
					next_cnt = '0;
					next_rst = 1'b0;
					next_state = adcss_pkg::ST_SETTLE;
				end
			end
			adcss_pkg::ST_SETTLE: begin
				next_cnt = cnt + 1'b1;
				if (cnt >= adcss_pkg::CNT_W'(adcss_pkg::SEL_CYC - 1)) begin
					next_cnt = '0;
					next_set = adcss_pkg::SET_TRIM;
					next_ptr = set_base_0;
					next_state = adcss_pkg::ST_FETCH;
				end
			end
			adcss_pkg::ST_FETCH: begin
				next_state = adcss_pkg::ST_LOAD; // memory read latency
			end
			adcss_pkg::ST_LOAD: begin
				if (mi.rdata == adcss_pkg::END_WORD) begin
					if (set == adcss_pkg::SET_IL_B) begin
						next_state = adcss_pkg::ST_ILWAIT;
					end else if (set == adcss_pkg::SET_LINK) begin
						next_busy = 1'b0;
						next_done = 1'b1;
						next_state = adcss_pkg::ST_DONE;
					end else begin
						next_set = set + 3'h1;
						next_state = adcss_pkg::ST_GAP;
					end
				end else begin
					next_shreg = mi.rdata;
					next_bitn = '0;
					next_cnt = '0;
					next_sel_n = 1'b0;
					next_state = adcss_pkg::ST_SHIFT;
				end
			end
			adcss_pkg::ST_SHIFT: begin
				next_sdata = shreg[23];
				next_cnt = cnt + 1'b1;
				if (cnt == adcss_pkg::CNT_W'(adcss_pkg::SCK_HALF - 1)) begin
					next_sclk = 1'b1;
				end else if (cnt == adcss_pkg::CNT_W'(2 * adcss_pkg::SCK_HALF - 1)) begin
					next_sclk = 1'b0;
					next_cnt = '0;
					next_shreg = {shreg[22:0], 1'b0};
					next_bitn = bitn + 5'h01;
					if (bitn == 5'(adcss_pkg::WR_BITS - 1)) begin
						next_sel_n = 1'b1;
						next_ptr = ptr + 8'h01;
						next_state = adcss_pkg::ST_FETCH;
					end
				end
			end
			adcss_pkg::ST_GAP: begin
				next_ptr = base;
				next_state = adcss_pkg::ST_FETCH;
			end
			adcss_pkg::ST_ILWAIT: begin
				next_cnt = cnt + 1'b1;
				if (cnt >= adcss_pkg::CNT_W'(adcss_pkg::ILWAIT_CYC - 1)) begin
					next_cnt = '0;
					next_set = adcss_pkg::SET_NL_A;
					next_ptr = set_base_3;
					next_state = adcss_pkg::ST_FETCH;
				end
			end
			adcss_pkg::ST_DONE: begin
				if (start) begin
					next_done = 1'b0;
					next_busy = 1'b1;
					next_rst = 1'b1;
					next_cnt = '0;
					next_state = adcss_pkg::ST_RST;
				end
			end
			default: begin
				next_state = adcss_pkg::ST_PWRUP;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= adcss_pkg::ST_PWRUP;
			cnt <= '0;
			ptr <= 8'h00;
			set <= 3'h0;
			shreg <= 24'h000000;
			bitn <= 5'h00;
			sysref_en <= 1'b0;
			dev_reset <= 1'b0;
			serial_port_select_n <= 1'b1;
			sclk <= 1'b0;
			sdata <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			cur_set <= 3'h0;
		end else if (ce) begin
			state <= next_state;
			cnt <= next_cnt;
			ptr <= next_ptr;
			set <= next_set;
			shreg <= next_shreg;
			bitn <= next_bitn;
			sysref_en <= next_sysref;
			dev_reset <= next_rst;
			serial_port_select_n <= next_sel_n;
			sclk <= next_sclk;
			sdata <= next_sdata;
			busy <= next_busy;
			done <= next_done;
			cur_set <= next_set;
		end
	end
endmodule : adcss_seq

// ### tb/adcss_seq_properties.sv
// pin-order checker for the start-up sequencer
`timescale 1ns/10ps
module adcss_seq_properties (
	// pins watched
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic start,
	input wire logic busy,
	input wire logic done,
	input wire logic [2:0] cur_set,
	input wire logic sysref_en,
	input wire logic dev_reset,
	input wire logic serial_port_select_n
);
	// ----
	// delay counters
	// ----
	logic [31:0] up_cnt, hi_cnt, lo_cnt;
	logic [31:0] next_up_cnt, next_hi_cnt, next_lo_cnt;
	always_comb begin
		next_up_cnt = sysref_en ? up_cnt + 32'h1 : up_cnt;
		next_hi_cnt = dev_reset ? hi_cnt + 32'h1 : 32'h0;
		next_lo_cnt = dev_reset ? 32'h0 : lo_cnt + 32'h1;
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			up_cnt <= 32'h0;
			hi_cnt <= 32'h0;
			lo_cnt <= 32'h0;
		end else begin
			up_cnt <= next_up_cnt;
			hi_cnt <= next_hi_cnt;
			lo_cnt <= next_lo_cnt;
		end
	end
	sequence rst_rise;
		$rose(dev_reset);
	endsequence
	sequence rst_fall;
		$fell(dev_reset);
	endsequence
	sequence sel_fall;
		$fell(serial_port_select_n);
	endsequence
	sequence done_rise;
		$rose(done);
	endsequence
	// a restart from done legally goes from the link set back to trim
	sequence set_step;
		$changed(cur_set) && $past(busy) && busy && $past(cur_set) != adcss_pkg::SET_LINK;
	endsequence
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_ref_first: assert property (rst_rise |-> sysref_en)
		else $error("reset before reference");
	a_pwrup_wait: assert property (rst_rise |-> up_cnt >= adcss_pkg::PWRUP_CYC)
		else $error("reset too early");
	a_reset_width: assert property (rst_fall |-> hi_cnt >= adcss_pkg::RST_CYC)
		else $error("reset pulse short");
	a_select_gap: assert property (sel_fall |-> lo_cnt >= adcss_pkg::SEL_CYC)
		else $error("select too soon");
	a_select_idle: assert property (dev_reset |-> serial_port_select_n)
		else $error("select during reset");
	a_done_holds: assert property (done && !start |=> done)
		else $error("done dropped");
	a_done_quiet: assert property (done_rise |-> serial_port_select_n
		&& cur_set == adcss_pkg::SET_LINK)
		else $error("done before link set");
	a_set_order: assert property (set_step |-> cur_set == $past(cur_set) + 3'h1)
		else $error("set order broken");
endmodule : adcss_seq_properties

bind adcss_seq adcss_seq_properties i_props (.sys_clk(sys_clk), .nrst(nrst), .start(start),
	.busy(busy), .done(done), .cur_set(cur_set), .sysref_en(sysref_en),
	.dev_reset(dev_reset), .serial_port_select_n(serial_port_select_n));

// ### tb/adcss_dev_model.sv
// behavioural converter that captures serial words
`timescale 1ns/10ps
module adcss_dev_model (
	// pins from host
	input wire logic dev_reset,
	input wire logic serial_port_select_n,
	input wire logic sclk,
	input wire logic sdata,
	// capture
	output logic [23:0] word,
	output logic [7:0] nwords
);
	logic [23:0] sh;
	int bits;
	initial begin
		word = 24'h0;
		nwords = 8'h0;
		bits = 0;
	end
	// active-high reset clears the word and bit counts, not the last word
	always @(posedge dev_reset) begin
		nwords <= 8'h0;
		bits <= 0;
	end
	always @(posedge sclk) begin
		if (serial_port_select_n === 1'b0) begin
			sh <= {sh[22:0], sdata};
			bits <= bits + 1;
		end
	end
	// only a whole word counts; a short frame is dropped
	always @(posedge serial_port_select_n) begin
		if (bits == 24) begin
			word <= sh;
			nwords <= nwords + 8'h1;
		end
		bits <= 0;
	end
endmodule : adcss_dev_model

// ### tb/tb_adc_startup_reset_sequence.sv
// bench for the start-up sequencer
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_adc_startup_reset_sequence;
	logic sys_clk = 1'b0, nrst = 1'b0, ce = 1'b1, start = 1'b0, tbl_we = 1'b0;
	logic [7:0] tbl_addr = 8'h00;
	logic [23:0] tbl_data = 24'h000000;
	// table start of each set, in load order
	logic [7:0] set_base [6] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h28};
	logic busy, done, sysref_en, dev_reset, serial_port_select_n, sclk, sdata;
	logic [2:0] cur_set;
	logic [23:0] word;
	logic [7:0] nwords;
	int n_fail = 0;
	int num_checks = 0;
	always #5 sys_clk = ~sys_clk;
	adcss_seq i_adcss_seq (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .start(start),
		.tbl_we(tbl_we), .tbl_addr(tbl_addr), .tbl_data(tbl_data), .set_base_0(set_base[0]),
		.set_base_1(set_base[1]), .set_base_2(set_base[2]), .set_base_3(set_base[3]),
		.set_base_4(set_base[4]), .set_base_5(set_base[5]), .busy(busy), .done(done),
		.cur_set(cur_set),
		.sysref_en(sysref_en), .dev_reset(dev_reset),
		.serial_port_select_n(serial_port_select_n), .sclk(sclk), .sdata(sdata));
	adcss_dev_model u_dev (.dev_reset(dev_reset), .serial_port_select_n(serial_port_select_n),
		.sclk(sclk), .sdata(sdata), .word(word), .nwords(nwords));
	// ----
	// tasks
	// ----
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask : tick
	task automatic t_pwrup();
		int n;
		`CHK("idle_sel", 1'b1, serial_port_select_n)
		`CHK("idle", 5'h01, {sysref_en, dev_reset, busy, done, serial_port_select_n})
		start = 1'b1;
		tick();
		start = 1'b0;
		tick();
		`CHK("sysref", 1'b1, sysref_en)
		n = 1;
		while (dev_reset !== 1'b1 && n < 200000) begin
			tick();
			n++;
		end
		`CHK("pwrup", 1'b1, n >= adcss_pkg::PWRUP_CYC)
		// ce low for 20 cycles inside the pulse must stretch it by exactly that much
		n = 0;
		while (dev_reset === 1'b1 && n < 1000) begin
			`CHK("rst_sel", 1'b1, serial_port_select_n)
			ce = (n < 20 || n >= 40);
			tick();
			n++;
		end
		ce = 1'b1;
		`CHK("rst_width", 1'b1, n == adcss_pkg::RST_CYC + 20)
	endtask : t_pwrup
	task automatic t_word(input logic [2:0] k);
		int n;
		logic [7:0] c0;
		c0 = nwords;
		n = 0;
		while (nwords === c0 && n < 3000) begin
			tick();
			n++;
		end
		`CHK("word", {16'hA5C3, 5'h00, k}, word)
		`CHK("set", k, cur_set)
	endtask : t_word
	task automatic t_ilwait();
		logic [7:0] c0;
		c0 = nwords;
		repeat (5000) tick();
		`CHK("il_quiet", c0, nwords)
		`CHK("il_busy", 2'b10, {busy, done})
	endtask : t_ilwait
	task automatic wrap_up();
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	// the 1 ms power-up wait dominates: about 106k cycles in all
	initial begin
		repeat (120000) @(posedge sys_clk);
		n_fail++;
		wrap_up();
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		#1;
		nrst = 1'b1;
		for (int k = 0; k < 6; k++) begin
			tbl_we = 1'b1;
			tbl_addr = set_base[k];
			tbl_data = {16'hA5C3, 5'h00, 3'(k)};
			tick();
			tbl_addr = set_base[k] + 8'h01;
			tbl_data = 24'hFFFFFF;
			tick();
		end
		tbl_we = 1'b0;
		t_pwrup();
		t_word(adcss_pkg::SET_TRIM);
		start = 1'b1;
		tick();
		start = 1'b0;
		t_word(adcss_pkg::SET_IL_A);
		t_word(adcss_pkg::SET_IL_B);
		t_ilwait();
		wrap_up();
	end
endmodule : tb_adc_startup_reset_sequence
